// ---- trig_seq_pkg.sv ----
package trig_seq_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_ADJUST  = 4'h1;
   localparam logic [3:0] OFS_LITERAL = 4'h2;
   localparam logic [3:0] OFS_STATUS  = 4'h3;
   localparam logic [3:0] OFS_COMMAND = 4'h4;

   // Control register fields
   localparam int CLK_SRC_LSB   = 13;
   localparam int PRESCALE_LSB  = 8;
   localparam int PWIDTH_LSB    = 4;
   localparam int WDT_LSB       = 0;
   localparam logic [15:0] CONTROL_MASK  = 16'hfff7;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] ADJUST_RESET  = 16'h0000;
   localparam logic [15:0] LITERAL_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_RESET   = 16'h0000;

   // Status register fields
   localparam int STAT_ENABLE_BIT = 0;
   localparam int STAT_START_BIT  = 1;
   localparam int STAT_TRIG_BIT   = 2;

   // Command register fields: bit 0 add, bit 1 literal copy, bit 2 trigger
   localparam int CMD_ADD_BIT   = 0;
   localparam int CMD_COPY_BIT  = 1;
   localparam int CMD_TRIG_BIT  = 2;
   localparam int CMD_TGT_LSB   = 4;

   // Add targets
   typedef enum logic [2:0] {
      TGT_TIMER0   = 3'b000,
      TGT_TIMER1   = 3'b001,
      TGT_COUNTER0 = 3'b010,
      TGT_COUNTER1 = 3'b011,
      TGT_STEP_DLY = 3'b100,
      TGT_LITERAL  = 3'b101
   } add_target_e;

endpackage

// ---- seq_prescaler.sv ----
`timescale 1ns/1ps
module seq_prescaler (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       src_tick,
   input  wire logic [4:0] divide,
   output logic            tick
);
   logic [4:0] count;
   logic [4:0] next_count;
   logic       next_tick;

   // Divide the source ticks by divide plus one
   always_comb begin
      next_count = count;
      next_tick  = 1'b0;
      if (src_tick) begin
         if (count >= divide) begin
            next_count = 5'h0_0;
            next_tick  = 1'b1;
         end else begin
            next_count = count + 5'h0_1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count <= 5'h0_0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end

   AST_DIV_ZERO: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (src_tick && divide == 5'h0_0 && count == 5'h0_0) |=> tick)
      else $error("Undivided source tick lost");

endmodule // seq_prescaler

// ---- trigger_sequencer_config.sv ----
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module trigger_sequencer_config (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        seq_enable_bit,
   input  wire logic        seq_start_bit,
   input  wire logic [7:0]  clk_src_ticks,
   output logic      [2:0]  seq_clock_source_sel,
   output logic      [2:0]  seq_watchdog_timeout_sel,
   output logic             seq_tick,
   output logic             trigger_out,
   output logic      [15:0] converter_channel_select,
   output logic      [15:0] step_delay_limit
);
   logic [15:0] control;
   logic [15:0] adjust_value;
   logic [15:0] literal_value;
   logic [15:0] timer_limit_regs [2];
   logic [15:0] counter_limit_regs [2];
   logic [15:0] next_control;
   logic [15:0] next_adjust;
   logic [15:0] next_literal;
   logic [15:0] next_timer [2];
   logic [15:0] next_counter [2];
   logic [15:0] next_step_delay;
   logic [15:0] next_chan;
   logic [15:0] next_rdata;
   logic        running;
   logic        add_cmd;
   logic        copy_cmd;
   logic        trig_cmd;
   logic [2:0]  add_tgt;
   logic [2:0]  src_sel;
   logic        src_tick;
   logic        pre_tick;
   logic [3:0]  pwidth;
   logic [4:0]  pulse_left;
   logic [4:0]  next_pulse_left;
   logic        next_trigger;

   function automatic logic [15:0] add16(input logic [15:0] a,
                                         input logic [15:0] b);
      add16 = a + b;
   endfunction

   assign running  = seq_enable_bit && seq_start_bit;
   assign add_cmd  = wr && addr == trig_seq_pkg::OFS_COMMAND
                     && wdata[trig_seq_pkg::CMD_ADD_BIT];
   assign copy_cmd = wr && addr == trig_seq_pkg::OFS_COMMAND
                     && wdata[trig_seq_pkg::CMD_COPY_BIT];
   assign trig_cmd = wr && addr == trig_seq_pkg::OFS_COMMAND
                     && wdata[trig_seq_pkg::CMD_TRIG_BIT];
   assign add_tgt  = wdata[trig_seq_pkg::CMD_TGT_LSB +: 3];
   assign src_sel  = control[trig_seq_pkg::CLK_SRC_LSB +: 3];
   assign pwidth   = control[trig_seq_pkg::PWIDTH_LSB +: 4];

   // Reserved source codes give no ticks, so the sequencer stalls
   assign src_tick = (src_sel < 3'b110) ? clk_src_ticks[src_sel] : 1'b0;

   seq_prescaler u_prescaler (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .src_tick (src_tick),
      .divide   (control[trig_seq_pkg::PRESCALE_LSB +: 5]),
      .tick     (pre_tick)
   );

   // Register file
   always_comb begin
      next_control    = control;
      next_adjust     = adjust_value;
      next_literal    = literal_value;
      next_timer      = timer_limit_regs;
      next_counter    = counter_limit_regs;
      next_step_delay = step_delay_limit;
      next_chan       = converter_channel_select;
      if (wr) begin
         unique case (addr)
            trig_seq_pkg::OFS_CONTROL:
               next_control = wdata & trig_seq_pkg::CONTROL_MASK;
            trig_seq_pkg::OFS_ADJUST:
               if (!running) next_adjust = wdata;
            trig_seq_pkg::OFS_LITERAL:
               if (!running) next_literal = wdata;
            default: ;
         endcase
      end
      if (add_cmd) begin
         unique case (add_tgt)
            trig_seq_pkg::TGT_TIMER0:
               next_timer[0] = add16(timer_limit_regs[0], adjust_value);
            trig_seq_pkg::TGT_TIMER1:
               next_timer[1] = add16(timer_limit_regs[1], adjust_value);
            trig_seq_pkg::TGT_COUNTER0:
               next_counter[0] = add16(counter_limit_regs[0], adjust_value);
            trig_seq_pkg::TGT_COUNTER1:
               next_counter[1] = add16(counter_limit_regs[1], adjust_value);
            trig_seq_pkg::TGT_STEP_DLY:
               next_step_delay = add16(step_delay_limit, adjust_value);
            trig_seq_pkg::TGT_LITERAL:
               next_literal = add16(literal_value, adjust_value);
            default: ;
         endcase
      end
      if (copy_cmd) next_chan = literal_value;
   end

   // Read data one cycle after the strobe; unmapped reads return zero
   always_comb begin
      next_rdata = 16'h0000;
      if (rd) begin
         unique case (addr)
            trig_seq_pkg::OFS_CONTROL: next_rdata = control;
            trig_seq_pkg::OFS_ADJUST:  next_rdata = adjust_value;
            trig_seq_pkg::OFS_LITERAL: next_rdata = literal_value;
            trig_seq_pkg::OFS_STATUS: begin
               next_rdata[trig_seq_pkg::STAT_ENABLE_BIT] = seq_enable_bit;
               next_rdata[trig_seq_pkg::STAT_START_BIT]  = seq_start_bit;
               next_rdata[trig_seq_pkg::STAT_TRIG_BIT]   = trigger_out;
            end
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // Trigger pulse counted in sequencer ticks
   always_comb begin
      next_pulse_left = pulse_left;
      next_trigger    = trigger_out;
      if (trig_cmd && pulse_left == 5'h0_0) begin
         next_pulse_left = {1'b0, pwidth} + 5'h0_1;
         next_trigger    = 1'b1;
      end else if (pre_tick && pulse_left != 5'h0_0) begin
         next_pulse_left = pulse_left - 5'h0_1;
         next_trigger    = (pulse_left != 5'h0_1);
      end
   end

   // Register file group
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         control                  <= trig_seq_pkg::CONTROL_RESET;
         adjust_value             <= trig_seq_pkg::ADJUST_RESET;
         literal_value            <= trig_seq_pkg::LITERAL_RESET;
         timer_limit_regs[0]      <= trig_seq_pkg::LIMIT_RESET;
         timer_limit_regs[1]      <= trig_seq_pkg::LIMIT_RESET;
         counter_limit_regs[0]    <= trig_seq_pkg::LIMIT_RESET;
         counter_limit_regs[1]    <= trig_seq_pkg::LIMIT_RESET;
         step_delay_limit         <= trig_seq_pkg::LIMIT_RESET;
         converter_channel_select <= trig_seq_pkg::LIMIT_RESET;
      end else begin
         control                  <= next_control;
         adjust_value             <= next_adjust;
         literal_value            <= next_literal;
         timer_limit_regs         <= next_timer;
         counter_limit_regs       <= next_counter;
         step_delay_limit         <= next_step_delay;
         converter_channel_select <= next_chan;
      end
   end

   // Read data group
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Pulse, tick and mirrored selects, all straight from flip-flops
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pulse_left               <= 5'h0_0;
         trigger_out              <= 1'b0;
         seq_tick                 <= 1'b0;
         seq_clock_source_sel     <= 3'b000;
         seq_watchdog_timeout_sel <= 3'b000;
      end else begin
         pulse_left               <= next_pulse_left;
         trigger_out              <= next_trigger;
         seq_tick                 <= pre_tick;
         seq_clock_source_sel     <=
            next_control[trig_seq_pkg::CLK_SRC_LSB +: 3];
         seq_watchdog_timeout_sel <= next_control[trig_seq_pkg::WDT_LSB +: 3];
      end
   end

   AST_PULSE_LOAD: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (trig_cmd && pulse_left == 5'h0_0) |=>
      (trigger_out && pulse_left == {1'b0, $past(pwidth)} + 5'h0_1))
      else $error("Pulse length not loaded from width field");
   AST_PULSE_END: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (pulse_left == 5'h0_1 && pre_tick && !trig_cmd) |=> !trigger_out)
      else $error("Trigger pulse outlived its width");
   AST_PULSE_HOLD: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (pulse_left != 5'h0_0 && !pre_tick) |=>
      ($stable(pulse_left) && trigger_out))
      else $error("Trigger pulse moved without a sequencer tick");
   AST_TRIG_LEVEL: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      trigger_out == (pulse_left != 5'h0_0))
      else $error("Trigger output disagrees with pulse count");

   AST_ADD_LIT: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (add_cmd && add_tgt == trig_seq_pkg::TGT_LITERAL) |=>
      literal_value == $past(literal_value) + $past(adjust_value))
      else $error("Literal add result wrong");
   AST_ADD_SDL: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (add_cmd && add_tgt == trig_seq_pkg::TGT_STEP_DLY) |=>
      step_delay_limit == $past(step_delay_limit) + $past(adjust_value))
      else $error("Step delay add result wrong");
   AST_ADD_TMR0: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (add_cmd && add_tgt == trig_seq_pkg::TGT_TIMER0) |=>
      timer_limit_regs[0] == $past(timer_limit_regs[0]) + $past(adjust_value))
      else $error("Timer 0 limit add result wrong");
   AST_ADD_TMR1: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (add_cmd && add_tgt == trig_seq_pkg::TGT_TIMER1) |=>
      timer_limit_regs[1] == $past(timer_limit_regs[1]) + $past(adjust_value))
      else $error("Timer 1 limit add result wrong");
   AST_ADD_CNT0: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (add_cmd && add_tgt == trig_seq_pkg::TGT_COUNTER0) |=>
      counter_limit_regs[0] ==
      $past(counter_limit_regs[0]) + $past(adjust_value))
      else $error("Counter 0 limit add result wrong");
   AST_ADD_CNT1: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (add_cmd && add_tgt == trig_seq_pkg::TGT_COUNTER1) |=>
      counter_limit_regs[1] ==
      $past(counter_limit_regs[1]) + $past(adjust_value))
      else $error("Counter 1 limit add result wrong");
   AST_COPY: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      copy_cmd |=> converter_channel_select == $past(literal_value))
      else $error("Channel select not loaded from literal");

   AST_LOCK: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (running && wr && addr == trig_seq_pkg::OFS_ADJUST) |=>
      $stable(adjust_value))
      else $error("Adjust written while running");
   AST_LOCK_LIT: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (running && wr && addr == trig_seq_pkg::OFS_LITERAL) |=>
      $stable(literal_value))
      else $error("Literal written while running");
   AST_BIT3: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && addr == trig_seq_pkg::OFS_CONTROL) |=> rdata[3] == 1'b0)
      else $error("Control bit 3 read as one");
   AST_RD_ADJ: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && addr == trig_seq_pkg::OFS_ADJUST) |=>
      rdata == $past(adjust_value))
      else $error("Adjust readback wrong");
   AST_RD_LIT: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && addr == trig_seq_pkg::OFS_LITERAL) |=>
      rdata == $past(literal_value))
      else $error("Literal readback wrong");
   AST_RD_CTRL: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && addr == trig_seq_pkg::OFS_CONTROL) |=>
      rdata == $past(control))
      else $error("Control readback wrong");
   AST_STATUS: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && addr == trig_seq_pkg::OFS_STATUS) |=>
      rdata == {13'h0000, $past(trigger_out), $past(seq_start_bit),
                $past(seq_enable_bit)})
      else $error("Status readback wrong");
   AST_MIRROR: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      seq_clock_source_sel == control[trig_seq_pkg::CLK_SRC_LSB +: 3] &&
      seq_watchdog_timeout_sel == control[trig_seq_pkg::WDT_LSB +: 3])
      else $error("Select outputs differ from control register");

   COV_PULSE: cover property (@(posedge clk_sys) trig_cmd ##1 trigger_out);
   COV_ADD:   cover property (@(posedge clk_sys) add_cmd);
   COV_COPY:  cover property (@(posedge clk_sys) copy_cmd);
   COV_LOCK:  cover property (@(posedge clk_sys) running && wr);
   COV_TRIG_READ: cover property (@(posedge clk_sys)
      rd && addr == trig_seq_pkg::OFS_STATUS && trigger_out);

endmodule // trigger_sequencer_config

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        en = 1'b0;
   logic        st = 1'b0;
   logic [7:0]  ticks = 8'h02;
   logic [15:0] rdata;
   logic [2:0]  src_sel;
   logic [2:0]  wdt_sel;
   logic        seq_tick;
   logic        trigger_out;
   logic [15:0] chan_sel;
   logic [15:0] sdly;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          n;

   always #50 clk_sys = ~clk_sys;

   trigger_sequencer_config u_dut (
      .clk_sys                  (clk_sys),
      .rst_n                    (rst_n),
      .addr                     (addr),
      .wdata                    (wdata),
      .wr                       (wr),
      .rd                       (rd),
      .rdata                    (rdata),
      .seq_enable_bit           (en),
      .seq_start_bit            (st),
      .clk_src_ticks            (ticks),
      .seq_clock_source_sel     (src_sel),
      .seq_watchdog_timeout_sel (wdt_sel),
      .seq_tick                 (seq_tick),
      .trigger_out              (trigger_out),
      .converter_channel_select (chan_sel),
      .step_delay_limit         (sdly)
   );

   task automatic conclude();
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string name, input logic [3:0] a,
                         input logic [15:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      chk(name, exp, rdata);
   endtask

   task automatic wait_tick();
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (seq_tick !== 1'b1 && n < 100);
   endtask

   // First gaps after a reconfiguration may be short, so skip two
   task automatic tick_gap(input logic [4:0] p);
      wr_reg(trig_seq_pkg::OFS_CONTROL, 16'h2000 | {3'h0, p, 8'h00});
      repeat (3) wait_tick();
      chk("tick_gap", {11'h000, p} + 16'h0001, n[15:0]);
   endtask

   task automatic pulse_len(input logic [3:0] w);
      wr_reg(trig_seq_pkg::OFS_CONTROL, 16'h2000 | {8'h00, w, 4'h0});
      wr_reg(trig_seq_pkg::OFS_COMMAND, 16'h0004);
      n = 0;
      repeat (40) begin
         @(negedge clk_sys);
         if (trigger_out === 1'b1) n++;
      end
      chk("pulse_len", {12'h000, w} + 16'h0001, n[15:0]);
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk("chan_sel_rst", 16'h0000, chan_sel);
      rd_chk("control_rst", trig_seq_pkg::OFS_CONTROL, 16'h0000);
      rd_chk("adjust_rst", trig_seq_pkg::OFS_ADJUST, 16'h0000);
      rd_chk("literal_rst", trig_seq_pkg::OFS_LITERAL, 16'h0000);
      wr_reg(trig_seq_pkg::OFS_CONTROL, 16'hffff);
      rd_chk("control_bit3", trig_seq_pkg::OFS_CONTROL, 16'hfff7);
      chk("src_sel", 16'h0007, {13'h0000, src_sel});
      chk("wdt_sel", 16'h0007, {13'h0000, wdt_sel});
      wr_reg(4'hf, 16'hbeef);
      rd_chk("unmapped", 4'hf, 16'h0000);
      wr_reg(trig_seq_pkg::OFS_ADJUST, 16'h0005);
      wr_reg(trig_seq_pkg::OFS_LITERAL, 16'hfffe);
      @(posedge clk_sys);
      en <= 1'b1;
      st <= 1'b1;
      wr_reg(trig_seq_pkg::OFS_ADJUST, 16'h1234);
      wr_reg(trig_seq_pkg::OFS_LITERAL, 16'h4321);
      rd_chk("adj_locked", trig_seq_pkg::OFS_ADJUST, 16'h0005);
      rd_chk("lit_locked", trig_seq_pkg::OFS_LITERAL, 16'hfffe);
      rd_chk("status", trig_seq_pkg::OFS_STATUS, 16'h0003);
      @(posedge clk_sys);
      st <= 1'b0;
      wr_reg(trig_seq_pkg::OFS_ADJUST, 16'h0007);
      rd_chk("adj_unlocked", trig_seq_pkg::OFS_ADJUST, 16'h0007);
      @(posedge clk_sys);
      en <= 1'b0;
      // Sum wraps past 16 bits
      wr_reg(trig_seq_pkg::OFS_COMMAND, 16'h0051);
      rd_chk("lit_add", trig_seq_pkg::OFS_LITERAL, 16'h0005);
      wr_reg(trig_seq_pkg::OFS_COMMAND, 16'h0041);
      wr_reg(trig_seq_pkg::OFS_COMMAND, 16'h0041);
      @(negedge clk_sys);
      chk("sdly_add", 16'h000e, sdly);
      for (int t = 0; t < 4; t++) begin
         wr_reg(trig_seq_pkg::OFS_COMMAND, {9'h000, t[2:0], 4'h1});
      end
      @(negedge clk_sys);
      chk("sdly_other", 16'h000e, sdly);
      rd_chk("lit_other", trig_seq_pkg::OFS_LITERAL, 16'h0005);
      wr_reg(trig_seq_pkg::OFS_COMMAND, 16'h0002);
      @(negedge clk_sys);
      chk("chan_copy", 16'h0005, chan_sel);
      tick_gap(5'h00);
      tick_gap(5'h02);
      tick_gap(5'h1f);
      // A reserved source code must stay silent even with every tick live
      @(posedge clk_sys);
      ticks <= 8'hff;
      wr_reg(trig_seq_pkg::OFS_CONTROL, 16'hc000);
      n = 0;
      repeat (10) begin
         @(negedge clk_sys);
         if (seq_tick !== 1'b0) n++;
      end
      chk("reserved_src", 16'h0000, n[15:0]);
      @(posedge clk_sys);
      ticks <= 8'h02;
      pulse_len(4'h0);
      pulse_len(4'hf);
      pulse_len(4'h5);
      wr_reg(trig_seq_pkg::OFS_COMMAND, 16'h0004);
      rd_chk("status_trig", trig_seq_pkg::OFS_STATUS, 16'h0004);
      conclude();
   end
endmodule // tb
